// File: hdl/cd_ecc_pkg.sv
// constants for the decoder special control, status and serial format registers
package cd_ecc_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [6:0] IDX_DEC_CTRL = 7'h30;
  localparam logic [6:0] IDX_SPECIAL = 7'h3C;
  localparam logic [6:0] IDX_ECC_STAT = 7'h3D;
  localparam logic [6:0] IDX_DSP_FMT = 7'h3E;
  localparam logic [6:0] IDX_HDR_ERAS = 7'h3F;
  localparam logic [6:0] IDX_RSVD = 7'h40;
  localparam logic [6:0] IDX_SUB_STAT = 7'h41;
  // ==========================================================
  // decoder control (own register)
  localparam int DC_DECODE_EN = 1;
  localparam int DC_BUFFER_EN = 2;
  localparam int DC_CORR_REQ = 3;
  localparam int DC_EDC_EN = 4;
  // special control
  localparam int SC_PACKET = 4;
  localparam int SC_AUDIO_SYNC = 3;
  localparam int SC_REPEAT = 2;
  // ecc status
  localparam int ES_INVALID = 7;
  localparam int ES_OVERFLOW = 6;
  localparam int ES_FATAL = 5;
  localparam int ES_UNCORR = 4;
  localparam int ES_CORRECTED = 3;
  localparam int ES_SYNC_MISS = 2;
  localparam int ES_SYNC_ILL = 1;
  // dsp serial format
  localparam int DF_DELAY = 6;
  localparam int DF_FWD_PKT = 5;
  localparam int DF_LEN_HI = 4;
  localparam int DF_LEN_LO = 3;
  localparam int DF_LSB_FIRST = 2;
  localparam int DF_LEFT_HIGH = 1;
  localparam int DF_FALL = 0;
  localparam logic [7:0] DSP_FMT_MASK = 8'h7F;
  // subcode status
  localparam int SS_CRC = 7;
  localparam int SS_FAULT = 6;
  // ==========================================================
  // reset value and stream figures
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [6:0] SUB_BYTES = 7'd96;
  localparam logic [5:0] WLEN_16 = 6'd16;
  localparam logic [5:0] WLEN_24 = 6'd24;
  localparam logic [5:0] WLEN_32 = 6'd32;
  localparam logic [5:0] WLEN_48 = 6'd48;
endpackage

// File: hdl/cd_ecc_status_regs.sv
// decoder special control, ecc/subcode status and dsp serial input block
`timescale 1ns/100ps
module cd_ecc_status_regs (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  // avalon-mm slave
  input wire logic [8:0] ADDRESS_I,
  input wire logic READ_I,
  input wire logic WRITE_I,
  input wire logic [3:0] BYTEENABLE_I,
  input wire logic [31:0] WRITEDATA_I,
  output logic [31:0] READDATA_O,
  output logic WAITREQUEST_O,
  // dsp serial pins
  input wire logic SERIAL_BIT_CLOCK_I,
  input wire logic LEFT_RIGHT_CLOCK_I,
  input wire logic SERIAL_DATA_IN_I,
  // received words toward the buffer
  output logic [15:0] WORD_O,
  output logic WORD_LEFT_O,
  output logic WORD_VALID_O,
  input wire logic WORD_READY_I,
  // subcode deserializer
  input wire logic SUB_BYTE_I,
  input wire logic SUB_SYNC_I,
  input wire logic SUB_DONE_I,
  input wire logic Q_CRC_FAIL_I,
  // correction engine results
  input wire logic ECC_DONE_I,
  input wire logic ECC_FATAL_I,
  input wire logic ECC_UNCORR_I,
  input wire logic ECC_CORRECTED_I,
  input wire logic SYNC_MISSING_I,
  input wire logic SYNC_ILLEGAL_I,
  input wire logic [3:0] HDR_ERR_I,
  input wire logic [3:0] SUBHDR_ERR_A_I,
  input wire logic [3:0] SUBHDR_ERR_B_I,
  // decoder controls
  output logic PACKET_DISC_READ_EN_O,
  output logic FORWARD_PACKET_STREAM_O,
  output logic ECC_MODE_O,
  output logic REPEAT_CORRECTION_START_O,
  output logic EDC_CHECK_START_O,
  output logic AUDIO_WRITE_EN_O
);

  // ==========================================================
  // register bus
  logic [7:0] dec_ctrl_ff, special_ff, ecc_stat_ff, dsp_fmt_ff, hdr_eras_ff, sub_stat_ff;
  logic wait_ff, unread_ff, ecc_mode_ff, rep_ff, edc_ff;
  logic [31:0] rdata_ff;
  wire [6:0] idx = ADDRESS_I[8:2];
  wire req = (READ_I | WRITE_I) & wait_ff;
  wire acc_wr = WRITE_I & ~wait_ff & BYTEENABLE_I[0]; // lands when waitrequest is seen low
  wire acc_rd = READ_I & wait_ff;
  wire [7:0] wd = WRITEDATA_I[7:0];

  function automatic logic hit(input logic [6:0] a, input logic [6:0] r);
    hit = (a == r);
  endfunction

  wire wr_dec = acc_wr & hit(idx, cd_ecc_pkg::IDX_DEC_CTRL);
  wire wr_spec = acc_wr & hit(idx, cd_ecc_pkg::IDX_SPECIAL);
  wire wr_fmt = acc_wr & hit(idx, cd_ecc_pkg::IDX_DSP_FMT);
  wire rd_stat = acc_rd & hit(idx, cd_ecc_pkg::IDX_ECC_STAT);

  // unmapped and reserved addresses read zero
  logic [7:0] rmux;
  always_comb begin
    case (idx)
      cd_ecc_pkg::IDX_DEC_CTRL: rmux = dec_ctrl_ff;
      cd_ecc_pkg::IDX_SPECIAL: rmux = special_ff;
      cd_ecc_pkg::IDX_ECC_STAT: rmux = ecc_stat_ff;
      cd_ecc_pkg::IDX_DSP_FMT: rmux = dsp_fmt_ff;
      cd_ecc_pkg::IDX_HDR_ERAS: rmux = hdr_eras_ff;
      cd_ecc_pkg::IDX_SUB_STAT: rmux = sub_stat_ff;
      default: rmux = cd_ecc_pkg::REG_RESET;
    endcase
  end

  // one wait cycle, answer on the second edge of the request
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wait_ff <= !req;
      if (acc_rd) begin
        rdata_ff <= {24'h00_0000, rmux};
      end
    end
  end

  // ==========================================================
  // control registers
  // only the writable fields are stored; repeat bit is a strobe and reads zero
  wire corr_req_wr = wr_dec & wd[cd_ecc_pkg::DC_CORR_REQ];
  wire dec_ready = dec_ctrl_ff[cd_ecc_pkg::DC_DECODE_EN] & dec_ctrl_ff[cd_ecc_pkg::DC_BUFFER_EN];
  wire [7:0] nxt_dec_ctrl = {3'b000, wd[cd_ecc_pkg::DC_EDC_EN], 1'b0,
    wd[cd_ecc_pkg::DC_BUFFER_EN], wd[cd_ecc_pkg::DC_DECODE_EN], 1'b0};
  wire [7:0] nxt_special = {3'b000, wd[cd_ecc_pkg::SC_PACKET],
    wd[cd_ecc_pkg::SC_AUDIO_SYNC], 3'b000};

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      dec_ctrl_ff <= cd_ecc_pkg::REG_RESET;
      special_ff <= cd_ecc_pkg::REG_RESET;
      dsp_fmt_ff <= cd_ecc_pkg::REG_RESET;
      ecc_mode_ff <= 1'b0;
      rep_ff <= 1'b0;
    end else begin
      if (wr_dec) begin
        dec_ctrl_ff <= nxt_dec_ctrl;
      end
      if (wr_spec) begin
        special_ff <= nxt_special;
      end
      if (wr_fmt) begin
        dsp_fmt_ff <= wd & cd_ecc_pkg::DSP_FMT_MASK;
      end
      // entry to ecc mode is judged on the enables already in place, exit on the written ones
      if (corr_req_wr && dec_ready) begin
        ecc_mode_ff <= 1'b1;
      end else if (wr_dec && !(wd[cd_ecc_pkg::DC_DECODE_EN] && wd[cd_ecc_pkg::DC_BUFFER_EN])) begin
        ecc_mode_ff <= 1'b0;
      end
      rep_ff <= wr_spec & wd[cd_ecc_pkg::SC_REPEAT];
    end
  end

  // ==========================================================
  // ecc status
  logic ovf_ev;
  wire blk_done = ECC_DONE_I & ecc_mode_ff;
  wire [7:0] nxt_ecc_stat = {(unread_ff | ecc_stat_ff[cd_ecc_pkg::ES_INVALID]) & ~rd_stat,
    1'b0, ECC_FATAL_I, ECC_UNCORR_I, ECC_CORRECTED_I, SYNC_MISSING_I, SYNC_ILLEGAL_I, 1'b0};

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      ecc_stat_ff <= cd_ecc_pkg::REG_RESET;
      hdr_eras_ff <= cd_ecc_pkg::REG_RESET;
      unread_ff <= 1'b0;
      edc_ff <= 1'b0;
    end else begin
      // a block result in the same cycle as a status read wins
      if (blk_done) begin
        ecc_stat_ff[cd_ecc_pkg::ES_INVALID] <= nxt_ecc_stat[cd_ecc_pkg::ES_INVALID] | unread_ff;
        ecc_stat_ff[cd_ecc_pkg::ES_FATAL:cd_ecc_pkg::ES_SYNC_ILL] <=
          nxt_ecc_stat[cd_ecc_pkg::ES_FATAL:cd_ecc_pkg::ES_SYNC_ILL];
        hdr_eras_ff <= {SUBHDR_ERR_A_I & SUBHDR_ERR_B_I, HDR_ERR_I};
        unread_ff <= 1'b1;
      end else if (rd_stat) begin
        ecc_stat_ff[cd_ecc_pkg::ES_INVALID] <= 1'b0;
        unread_ff <= 1'b0;
      end
      if (ovf_ev) begin
        ecc_stat_ff[cd_ecc_pkg::ES_OVERFLOW] <= 1'b1;
      end else if (rd_stat) begin
        ecc_stat_ff[cd_ecc_pkg::ES_OVERFLOW] <= 1'b0;
      end
      edc_ff <= blk_done & dec_ctrl_ff[cd_ecc_pkg::DC_EDC_EN];
    end
  end

  // ==========================================================
  // subcode status and audio gating
  logic [6:0] sub_cnt_ff;
  logic sub_seen_ff;
  wire sub_over = SUB_BYTE_I && (sub_cnt_ff == cd_ecc_pkg::SUB_BYTES);
  wire sub_bad_sync = SUB_SYNC_I && (sub_cnt_ff != cd_ecc_pkg::SUB_BYTES);

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      sub_cnt_ff <= 7'd0;
      sub_stat_ff <= cd_ecc_pkg::REG_RESET;
      sub_seen_ff <= 1'b0;
    end else begin
      if (SUB_SYNC_I) begin
        sub_cnt_ff <= 7'd0;
      end else if (SUB_BYTE_I && !sub_over) begin
        sub_cnt_ff <= sub_cnt_ff + 7'd1;
      end
      // first sync after reset only marks the start of counting
      if ((sub_bad_sync && sub_seen_ff) || sub_over) begin
        sub_stat_ff[cd_ecc_pkg::SS_FAULT] <= 1'b1;
      end else if (SUB_DONE_I) begin
        sub_stat_ff[cd_ecc_pkg::SS_FAULT] <= 1'b0;
      end
      if (SUB_DONE_I) begin
        sub_stat_ff[cd_ecc_pkg::SS_CRC] <= Q_CRC_FAIL_I;
      end
      if (!special_ff[cd_ecc_pkg::SC_AUDIO_SYNC]) begin
        sub_seen_ff <= SUB_SYNC_I | sub_seen_ff;
      end else if (SUB_SYNC_I) begin
        sub_seen_ff <= 1'b1;
      end
    end
  end

  logic audio_arm_ff;
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      audio_arm_ff <= 1'b0;
    end else if (wr_spec && wd[cd_ecc_pkg::SC_AUDIO_SYNC]) begin
      audio_arm_ff <= 1'b0;
    end else if (SUB_SYNC_I) begin
      audio_arm_ff <= 1'b1;
    end
  end
  wire audio_ok = !special_ff[cd_ecc_pkg::SC_AUDIO_SYNC] | audio_arm_ff;

  // ==========================================================
  // dsp serial input
  logic bck_m_ff, bck_s_ff, bck_d_ff, lr_m_ff, lr_s_ff, lr_d_ff, sd_m_ff, sd_s_ff;
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      {bck_m_ff, bck_s_ff, bck_d_ff} <= 3'b000;
      {lr_m_ff, lr_s_ff, lr_d_ff} <= 3'b000;
      {sd_m_ff, sd_s_ff} <= 2'b00;
    end else begin
      {bck_m_ff, bck_s_ff, bck_d_ff} <= {SERIAL_BIT_CLOCK_I, bck_m_ff, bck_s_ff};
      {lr_m_ff, lr_s_ff, lr_d_ff} <= {LEFT_RIGHT_CLOCK_I, lr_m_ff, lr_s_ff};
      {sd_m_ff, sd_s_ff} <= {SERIAL_DATA_IN_I, sd_m_ff};
    end
  end

  wire fmt_fall = dsp_fmt_ff[cd_ecc_pkg::DF_FALL];
  wire fmt_fwd = dsp_fmt_ff[cd_ecc_pkg::DF_FWD_PKT];
  wire bit_edge = fmt_fall ? (bck_d_ff & ~bck_s_ff) : (bck_s_ff & ~bck_d_ff);
  // in forward packet mode words are framed by count alone, not by the channel clock
  wire lr_change = (lr_s_ff ^ lr_d_ff) & ~fmt_fwd;
  logic [5:0] wlen;
  always_comb begin
    case (dsp_fmt_ff[cd_ecc_pkg::DF_LEN_HI:cd_ecc_pkg::DF_LEN_LO])
      2'b00: wlen = cd_ecc_pkg::WLEN_16;
      2'b01: wlen = cd_ecc_pkg::WLEN_24;
      2'b10: wlen = cd_ecc_pkg::WLEN_32;
      default: wlen = cd_ecc_pkg::WLEN_48;
    endcase
  end

  logic [5:0] bit_cnt_ff;
  logic [15:0] shift_ff;
  logic prev_bit_ff, chan_ff;
  // the delayed sample is the bit seen on the previous bit clock edge
  wire sbit = dsp_fmt_ff[cd_ecc_pkg::DF_DELAY] ? prev_bit_ff : sd_s_ff;
  wire word_end = bit_edge && (bit_cnt_ff == wlen - 6'd1);
  wire [15:0] sh_now = (bit_cnt_ff < cd_ecc_pkg::WLEN_16) ? {shift_ff[14:0], sbit} : shift_ff;
  wire [15:0] word_asm = dsp_fmt_ff[cd_ecc_pkg::DF_LSB_FIRST] ?
    {sh_now[7:0], sh_now[15:8]} : sh_now;
  wire is_left = (lr_s_ff == dsp_fmt_ff[cd_ecc_pkg::DF_LEFT_HIGH]);

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      bit_cnt_ff <= 6'd0;
      shift_ff <= 16'h0000;
      prev_bit_ff <= 1'b0;
      chan_ff <= 1'b0;
    end else if (lr_change) begin
      bit_cnt_ff <= 6'd0;
      chan_ff <= is_left;
    end else if (bit_edge) begin
      prev_bit_ff <= sd_s_ff;
      shift_ff <= sh_now;
      bit_cnt_ff <= word_end ? 6'd0 : bit_cnt_ff + 6'd1;
      if (bit_cnt_ff == 6'd0) begin
        chan_ff <= is_left;
      end
    end
  end

  // one-word holding stage; a new word while it is full and not being taken is an overflow
  logic [15:0] word_ff;
  logic wleft_ff, wvalid_ff;
  wire push = word_end & audio_ok & ~lr_change;
  assign ovf_ev = push & wvalid_ff & ~WORD_READY_I;

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      word_ff <= 16'h0000;
      wleft_ff <= 1'b0;
      wvalid_ff <= 1'b0;
    end else if (push && !ovf_ev) begin
      word_ff <= word_asm;
      wleft_ff <= chan_ff;
      wvalid_ff <= 1'b1;
    end else if (WORD_READY_I) begin
      wvalid_ff <= 1'b0;
    end
  end

  logic audio_en_ff;
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      audio_en_ff <= 1'b0;
    end else begin
      audio_en_ff <= audio_ok;
    end
  end

  // ==========================================================
  // outputs
  assign READDATA_O = rdata_ff;
  assign WAITREQUEST_O = wait_ff;
  assign WORD_O = word_ff;
  assign WORD_LEFT_O = wleft_ff;
  assign WORD_VALID_O = wvalid_ff;
  assign PACKET_DISC_READ_EN_O = special_ff[cd_ecc_pkg::SC_PACKET];
  assign FORWARD_PACKET_STREAM_O = dsp_fmt_ff[cd_ecc_pkg::DF_FWD_PKT];
  assign ECC_MODE_O = ecc_mode_ff;
  assign REPEAT_CORRECTION_START_O = rep_ff;
  assign EDC_CHECK_START_O = edc_ff;
  assign AUDIO_WRITE_EN_O = audio_en_ff;

  // ==========================================================
  // checks
  sequence s_status_read;
    READ_I && wait_ff && (idx == cd_ecc_pkg::IDX_ECC_STAT);
  endsequence
  sequence s_block_done;
    ECC_DONE_I && ecc_mode_ff;
  endsequence

  a_invalid_on_overwrite: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    (s_block_done and unread_ff) |=> ecc_stat_ff[cd_ecc_pkg::ES_INVALID])
    else $error("unread status overwritten without invalid flag");
  a_read_clears_invalid: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    (s_status_read and !ECC_DONE_I) |=> !ecc_stat_ff[cd_ecc_pkg::ES_INVALID] && !unread_ff)
    else $error("status read did not clear invalid");
  a_overflow_flag: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    ovf_ev |=> ecc_stat_ff[cd_ecc_pkg::ES_OVERFLOW])
    else $error("overflow not flagged");
  a_fatal_capture: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    s_block_done |=> ecc_stat_ff[cd_ecc_pkg::ES_FATAL] == $past(ECC_FATAL_I)
      && ecc_stat_ff[cd_ecc_pkg::ES_SYNC_MISS] == $past(SYNC_MISSING_I))
    else $error("block result not captured");
  a_subheader_both: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    s_block_done |=> hdr_eras_ff[7:4] == ($past(SUBHDR_ERR_A_I) & $past(SUBHDR_ERR_B_I)))
    else $error("subheader erasure not both copies");
  a_repeat_pulse: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    (wr_spec && wd[cd_ecc_pkg::SC_REPEAT]) |=> REPEAT_CORRECTION_START_O ##1 !rep_ff)
    else $error("repeat correction strobe wrong");
  a_ecc_mode_entry: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    (corr_req_wr && dec_ready) |=> ECC_MODE_O)
    else $error("correction request did not enter ecc mode");
  a_edc_after_ecc: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    EDC_CHECK_START_O |-> $past(ECC_DONE_I) && $past(dec_ctrl_ff[cd_ecc_pkg::DC_EDC_EN]))
    else $error("edc start without finished block");
  a_sub_fault: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    sub_over |=> sub_stat_ff[cd_ecc_pkg::SS_FAULT])
    else $error("late subcode sync not flagged");
  a_audio_held: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    (special_ff[cd_ecc_pkg::SC_AUDIO_SYNC] && !audio_arm_ff) |-> !push)
    else $error("audio written before first subcode");
  a_bus_answer: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    (READ_I || WRITE_I) && wait_ff |=> !WAITREQUEST_O ##1 WAITREQUEST_O)
    else $error("bus answer not in one wait cycle");

endmodule

// File: dv/dsp_stream_model.sv
// behavioural cd dsp serial source with a gated bit clock
`timescale 1ns/100ps
module dsp_stream_model (
  // serial pins
  output logic bck_o,
  output logic left_right_clock_o,
  output logic serial_data_in_o
);
  logic last_bit = 1'b0;
  initial begin
    bck_o = 1'b0;
    left_right_clock_o = 1'b0;
    serial_data_in_o = 1'b0;
  end
  // ==========================================================
  // frame sender
  // data is set a quarter period before the rise and held past the fall, so one
  // stream serves both latch edges; period is 125 ns
  task automatic send(input logic [47:0] v, input int n, input logic lr);
    left_right_clock_o = lr;
    for (int i = 0; i < n; i++) begin
      serial_data_in_o = v[47 - i];
      #31 bck_o = 1'b1;
      #62 bck_o = 1'b0;
      #32 last_bit = v[47 - i];
    end
    // clock stands still between frames and data no longer holds
    serial_data_in_o = ~last_bit;
  endtask
endmodule

// File: dv/tb_top.sv
// self-checking bench for the decoder status registers and dsp serial input
`timescale 1ns/100ps
module tb_top;
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] adr = 9'h000;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [3:0] be = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq, serial_bit_clock, left_right_clock, sdat, w_left, w_valid, pkt, fwd, ecc_mode, rep, edc, aud_en;
  logic [15:0] w_data;
  logic w_ready = 1'b0, hold = 1'b0;
  logic s_byte = 1'b0, s_sync = 1'b0, s_done = 1'b0, q_fail = 1'b0, e_done = 1'b0;
  logic [4:0] flg = 5'h00;
  logic [3:0] hdr = 4'h0, sha = 4'h0, shb = 4'h0;
  logic [31:0] rnd = 32'h40F5531A;
  logic [7:0] fmt = 8'h00;
  logic [11:0] hv;
  logic [16:0] wq[$];
  logic [15:0] rq[$];
  logic [15:0] e;
  int lens[4] = '{cd_ecc_pkg::WLEN_16, cd_ecc_pkg::WLEN_24, cd_ecc_pkg::WLEN_32,
                  cd_ecc_pkg::WLEN_48};
  logic [8:0] ra[7] = '{9'h0F0, 9'h0F4, 9'h0F8, 9'h0FC, 9'h100, 9'h104, 9'h1FC};
  logic [7:0] ff[7] = '{8'h18, 8'h00, 8'h7F, 8'h00, 8'h00, 8'h00, 8'h00};
  int n_mismatch = 0;
  int check_count = 0;
  int n_rep = 0;
  int n_edc = 0;
  // ==========================================================
  // design and serial source
  cd_ecc_status_regs u_dut (
    .CLOCK_I(clk), .RESET_N_I(rst_n),
    .ADDRESS_I(adr), .READ_I(rd_en), .WRITE_I(wr_en), .BYTEENABLE_I(be),
    .WRITEDATA_I(wdat), .READDATA_O(rdat), .WAITREQUEST_O(wreq),
    .SERIAL_BIT_CLOCK_I(serial_bit_clock), .LEFT_RIGHT_CLOCK_I(left_right_clock), .SERIAL_DATA_IN_I(sdat),
    .WORD_O(w_data), .WORD_LEFT_O(w_left), .WORD_VALID_O(w_valid), .WORD_READY_I(w_ready),
    .SUB_BYTE_I(s_byte), .SUB_SYNC_I(s_sync), .SUB_DONE_I(s_done), .Q_CRC_FAIL_I(q_fail),
    .ECC_DONE_I(e_done), .ECC_FATAL_I(flg[4]), .ECC_UNCORR_I(flg[3]),
    .ECC_CORRECTED_I(flg[2]), .SYNC_MISSING_I(flg[1]), .SYNC_ILLEGAL_I(flg[0]),
    .HDR_ERR_I(hdr), .SUBHDR_ERR_A_I(sha), .SUBHDR_ERR_B_I(shb),
    .PACKET_DISC_READ_EN_O(pkt), .FORWARD_PACKET_STREAM_O(fwd), .ECC_MODE_O(ecc_mode),
    .REPEAT_CORRECTION_START_O(rep), .EDC_CHECK_START_O(edc), .AUDIO_WRITE_EN_O(aud_en)
  );
  dsp_stream_model u_src (.bck_o(serial_bit_clock), .left_right_clock_o(left_right_clock), .serial_data_in_o(sdat));
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic cmp(input string what, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_word(input logic [16:0] got, input logic [16:0] ex);
    cmp("word", {15'h0, got}, {15'h0, ex});
  endtask
  task automatic cmp_read(input logic [31:0] got, input logic [15:0] ex);
    cmp("read", got & {24'hFFFFFF, ex[7:0]}, {24'h000000, ex[15:8]});
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // avalon master: request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d,
                     input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    rd_en <= !w;
    wr_en <= w;
    adr <= a;
    wdat <= {24'h0, d};
    be <= b;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 100);
    if (n >= 100) cmp("bus hang", 32'd1, 32'd0);
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
    repeat (2) @(posedge clk);
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] x, input logic [7:0] m);
    rq.push_back({x, m});
    bus(1'b0, a, 8'h00, 4'hF);
  endtask
  task automatic xfer(input logic ex);
    logic [47:0] v;
    logic [15:0] r;
    logic lr;
    lr = !left_right_clock;
    v = {rnd, rnd[31:16] ^ 16'hA5C3};
    r = fmt[6] ? {u_src.last_bit, v[47:33]} : v[47:32];
    if (fmt[2]) r = {r[7:0], r[15:8]};
    if (ex) wq.push_back({fmt[1] ? lr : !lr, r});
    u_src.send(v, lens[fmt[4:3]], lr);
  endtask
  task automatic drain();
    repeat (400) if (wq.size() > 0) @(posedge clk);
    cmp("words left", wq.size(), 32'd0);
    repeat (20) @(posedge clk);
  endtask
  task automatic subs(input int n, input logic d, input logic q);
    repeat (n) begin
      @(posedge clk) s_byte <= 1'b1;
      @(posedge clk) s_byte <= 1'b0;
    end
    @(posedge clk) s_sync <= 1'b1;
    @(posedge clk) s_sync <= 1'b0;
    if (d) begin
      q_fail <= q;
      s_done <= 1'b1;
      @(posedge clk) s_done <= 1'b0;
    end
  endtask
  task automatic blk(input logic [4:0] f);
    hv = rnd[11:0];
    @(posedge clk);
    flg <= f;
    {shb, sha, hdr} <= hv;
    e_done <= 1'b1;
    @(posedge clk) e_done <= 1'b0;
  endtask
  // ==========================================================
  // clock, sink and monitor
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    rnd <= lfsr(rnd);
    w_ready <= !hold && (rnd[1:0] != 2'b00);
    if (rep === 1'b1) n_rep++;
    if (edc === 1'b1) n_edc++;
    if (w_valid === 1'b1 && w_ready === 1'b1) begin
      if (wq.size() == 0) cmp("extra word", 32'd1, 32'd0);
      else cmp_word({w_left, w_data}, wq.pop_front());
    end
    if (rd_en === 1'b1 && wreq === 1'b0 && rq.size() > 0) begin
      e = rq.pop_front();
      cmp_read(rdat, e);
    end
  end
  initial begin
    #300000;
    cmp("timeout", 32'd1, 32'd0);
    complete_run();
  end
  // ==========================================================
  // tests
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ra[i]) rd(ra[i], 8'h00, 8'hFF);
    foreach (ra[i]) begin
      wr(ra[i], 8'hFF);
      rd(ra[i], ff[i], 8'hFF);
    end
    cmp("packet", pkt, 32'd1);
    cmp("fwd", fwd, 32'd1);
    cmp("audio", aud_en, 32'd0);
    bus(1'b1, 9'h0F8, 8'h00, 4'hE);
    rd(9'h0F8, 8'h7F, 8'hFF);
    wr(9'h0F0, 8'h00);
    wr(9'h0F8, 8'h00);
    cmp("packet", pkt, 32'd0);
    cmp("fwd", fwd, 32'd0);
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      fmt = {1'b0, k[2], k[0], k[1:0], k[0] ^ k[2], k[1], k[2] ^ k[1]};
      wr(9'h0F8, fmt);
      cmp("fwd", fwd, {31'h0, k[0]});
      xfer(1'b1);
      xfer(1'b1);
      drain();
    end
    $display("test serial formats done");
    hold <= 1'b1;
    xfer(1'b1);
    xfer(1'b0);
    hold <= 1'b0;
    drain();
    rd(9'h0F4, 8'h40, 8'h40);
    rd(9'h0F4, 8'h00, 8'h40);
    wr(9'h0F0, 8'h08);
    cmp("audio", aud_en, 32'd0);
    xfer(1'b0);
    drain();
    subs(0, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    cmp("audio", aud_en, 32'd1);
    xfer(1'b1);
    drain();
    wr(9'h0F0, 8'h00);
    $display("test overflow and audio sync done");
    subs(96, 1'b1, 1'b1);
    rd(9'h104, 8'h80, 8'hFF);
    subs(50, 1'b0, 1'b0);
    rd(9'h104, 8'h40, 8'h40);
    subs(96, 1'b1, 1'b0);
    rd(9'h104, 8'h00, 8'hFF);
    subs(97, 1'b0, 1'b0);
    rd(9'h104, 8'h40, 8'h40);
    $display("test subcode done");
    wr(9'h0C0, 8'h08);
    cmp("ecc mode", ecc_mode, 32'd0);
    wr(9'h0C0, 8'h16);
    wr(9'h0C0, 8'h1E);
    cmp("ecc mode", ecc_mode, 32'd1);
    for (int i = 0; i < 6; i++) begin
      blk(i < 5 ? 5'h01 << i : 5'h00);
      rd(9'h0F4, {2'b00, flg, 1'b0}, 8'hFF);
      rd(9'h0FC, {hv[7:4] & hv[11:8], hv[3:0]}, 8'hFF);
    end
    blk(5'h00);
    blk(5'h00);
    rd(9'h0F4, 8'h80, 8'h80);
    rd(9'h0F4, 8'h00, 8'h80);
    wr(9'h0C0, 8'h00);
    cmp("ecc mode", ecc_mode, 32'd0);
    blk(5'h1F);
    rd(9'h0F4, 8'h00, 8'hFF);
    cmp("edc count", n_edc, 32'd8);
    cmp("repeat count", n_rep, 32'd1);
    $display("test ecc status done");
    complete_run();
  end
endmodule
